// ==== hdl/tsc_pkg.sv ====
// Constants, register map and types of the temperature readout path.
// Assumes one 20 MHz system clock and a 32-bit AXI4-Lite register bus.
package tsc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  // Converter rate in tenths of a sample per second (62.5 ksps)
  localparam int unsigned SAMPLE_RATE_X10 = 625_000;
  localparam int unsigned SAMPLE_CYCLES   = (CLK_HZ * 10) / SAMPLE_RATE_X10;
  localparam int unsigned SAMPLE_CNT_W    = $clog2(SAMPLE_CYCLES);
  // Converter settling time after power-on, least value
  localparam int unsigned PWRUP_TIME_NS   = 10_000;
  localparam int unsigned PWRUP_CYCLES    =
    (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PWRUP_CNT_W     = $clog2(PWRUP_CYCLES);

  // ==========================================================
  // Data path widths
  localparam int unsigned SAMPLE_W  = 14;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned LUT_AW    = 12;
  localparam int unsigned LUT_DEPTH = 4096;
  localparam int unsigned TRUNC_LSB = 2;
  localparam int unsigned AVG_DEPTH = 8;
  localparam int unsigned AVG_PTR_W = 3;
  // Gain of the linear stage, fixed
  localparam logic [WORD_W-1:0] COMP_GAIN = 16'h0001;
  // Sensor routing: amplifier channel 0, single-ended positive input
  localparam logic [1:0] SENSOR_CHANNEL = 2'h0;
  localparam logic       SENSOR_SE      = 1'b1;

  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned AXI_AW = 8;
  localparam logic [AXI_AW-1:0] REG_CTRL     = 8'h00;
  localparam logic [AXI_AW-1:0] REG_TRIM     = 8'h04;
  localparam logic [AXI_AW-1:0] REG_STATUS   = 8'h08;
  localparam logic [AXI_AW-1:0] REG_RESULT0  = 8'h0c;
  localparam logic [AXI_AW-1:0] REG_RESULT1  = 8'h10;
  localparam logic [AXI_AW-1:0] REG_LUT_IDX  = 8'h14;
  localparam logic [AXI_AW-1:0] REG_LUT_DATA = 8'h18;

  // Field positions
  localparam int unsigned CTRL_CONV_EN_BIT   = 0;
  localparam int unsigned CTRL_SUBTRACT_BIT  = 1;
  localparam int unsigned STAT_READY_BIT     = 0;
  localparam int unsigned STAT_PRIMED0_BIT   = 1;
  localparam int unsigned STAT_PRIMED1_BIT   = 2;

  // Reset values
  localparam logic [1:0]        CTRL_RESET = 2'h1;
  localparam logic [WORD_W-1:0] TRIM_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Converter power sequencer, Gray coded along off-wait-on
  typedef enum logic [1:0] {
    TSC_PWR_OFF  = 2'h0,
    TSC_PWR_WAIT = 2'h1,
    TSC_PWR_ON   = 2'h3
  } tsc_pwr_t;

endpackage : tsc_pkg

// ==== hdl/tsc_avg.sv ====
// Moving average over the last eight words, one result per input.
// Assumes input strobes come from logic on the same clock.
module tsc_avg
  import tsc_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  input  wire logic         clk_en_in,
  input  wire logic [W-1:0] din_in,
  input  wire logic         din_valid_in,
  output logic      [W-1:0] dout_out,
  output logic              dout_valid_out,
  output logic              primed_out
);

  // ==========================================================
  // Window storage and running sum
  logic [W-1:0]         win_q [AVG_DEPTH];
  logic [W-1:0]         win_d [AVG_DEPTH];
  logic [W+2:0]         sum_q, sum_d;
  logic [AVG_PTR_W-1:0] ptr_q, ptr_d;
  logic [W-1:0]         out_q, out_d;
  logic                 vld_q, vld_d;
  logic                 primed_q, primed_d;

  always_comb begin
    win_d    = win_q;
    sum_d    = sum_q;
    ptr_d    = ptr_q;
    out_d    = out_q;
    primed_d = primed_q;
    vld_d    = 1'b0;
    if (din_valid_in) begin
      // Oldest word leaves as the new one enters
      sum_d        = sum_q + {3'h0, din_in} - {3'h0, win_q[ptr_q]};
      win_d[ptr_q] = din_in;
      ptr_d        = ptr_q + 3'h1;
      out_d        = sum_d[W+2:3];
      vld_d        = 1'b1;
      if (ptr_q == 3'h7) begin
        primed_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < AVG_DEPTH; i++) begin
        win_q[i] <= '0;
      end
      sum_q    <= '0;
      ptr_q    <= '0;
      out_q    <= '0;
      vld_q    <= 1'b0;
      primed_q <= 1'b0;
    end else if (clk_en_in) begin
      win_q    <= win_d;
      sum_q    <= sum_d;
      ptr_q    <= ptr_d;
      out_q    <= out_d;
      vld_q    <= vld_d;
      primed_q <= primed_d;
    end
  end

  assign dout_out       = out_q;
  assign dout_valid_out = vld_q & clk_en_in;
  assign primed_out     = primed_q;

endmodule : tsc_avg

// ==== hdl/tsc_top.sv ====
// Temperature readout path: converter sequencing, averaging, table
// lookup, linear trim and final averaging, behind AXI4-Lite.
// Assumes the converter sits on the same clock and answers each start
// pulse with one sample strobe.
module tsc_top
  import tsc_pkg::*;
(
  input  wire logic                clk_sys_in,
  input  wire logic                srst_in,
  input  wire logic                clk_en_in,
  // AXI4-Lite slave
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr_in,
  input  wire logic                s_axi_awvalid_in,
  output logic                     s_axi_awready_out,
  input  wire logic [31:0]         s_axi_wdata_in,
  input  wire logic [3:0]          s_axi_wstrb_in,
  input  wire logic                s_axi_wvalid_in,
  output logic                     s_axi_wready_out,
  output logic [1:0]               s_axi_bresp_out,
  output logic                     s_axi_bvalid_out,
  input  wire logic                s_axi_bready_in,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr_in,
  input  wire logic                s_axi_arvalid_in,
  output logic                     s_axi_arready_out,
  output logic [31:0]              s_axi_rdata_out,
  output logic [1:0]               s_axi_rresp_out,
  output logic                     s_axi_rvalid_out,
  input  wire logic                s_axi_rready_in,
  // Converter
  input  wire logic [SAMPLE_W-1:0] adc_data_in,
  input  wire logic                adc_valid_in,
  output logic                     adc_power_en_out,
  output logic                     adc_start_out,
  output logic [1:0]               adc_chan_sel_out,
  output logic                     adc_single_ended_out,
  // Final result towards the serial host port
  output logic [WORD_W-1:0]        result_out,
  output logic                     result_valid_out
);

  // ==========================================================
  // Byte-lane merge, used by every writable register
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // ==========================================================
  // Register state
  logic [1:0]        ctrl_q, ctrl_d;
  logic [WORD_W-1:0] trim_q, trim_d;
  logic [LUT_AW-1:0] lut_idx_q, lut_idx_d;
  logic              lut_we;
  logic [WORD_W-1:0] lut_wdata;
  logic [WORD_W-1:0] lut_q [LUT_DEPTH];

  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              wr_hs, rd_hs;

  logic              conv_en, subtract;
  logic              primed0, primed1;
  logic [SAMPLE_W-1:0] avg0;
  logic              avg0_vld;
  logic              conv_ready;

  assign conv_en  = ctrl_q[CTRL_CONV_EN_BIT];
  assign subtract = ctrl_q[CTRL_SUBTRACT_BIT];

  // Write taken only with address and data together, one at a time
  assign wr_hs = s_axi_awvalid_in & s_axi_wvalid_in & ~bvalid_q & clk_en_in;
  assign rd_hs = s_axi_arvalid_in & ~rvalid_q & clk_en_in;
  assign s_axi_awready_out = wr_hs;
  assign s_axi_wready_out  = wr_hs;
  assign s_axi_arready_out = rd_hs;

  // ==========================================================
  // Write side
  always_comb begin
    logic [31:0] m;
    m         = '0;
    ctrl_d    = ctrl_q;
    trim_d    = trim_q;
    lut_idx_d = lut_idx_q;
    lut_we    = 1'b0;
    lut_wdata = '0;
    bvalid_d  = bvalid_q & ~s_axi_bready_in;
    bresp_d   = bresp_q;
    if (wr_hs) begin
      bvalid_d = 1'b1;
      bresp_d  = RESP_OKAY;
      case (s_axi_awaddr_in)
        REG_CTRL: begin
          m      = merge_strb({30'h0, ctrl_q}, s_axi_wdata_in,
                              s_axi_wstrb_in);
          ctrl_d = m[1:0];
        end
        REG_TRIM: begin
          m      = merge_strb({16'h0, trim_q}, s_axi_wdata_in,
                              s_axi_wstrb_in);
          trim_d = m[WORD_W-1:0];
        end
        REG_LUT_IDX: begin
          m         = merge_strb({20'h0, lut_idx_q}, s_axi_wdata_in,
                                 s_axi_wstrb_in);
          lut_idx_d = m[LUT_AW-1:0];
        end
        // Index steps so the table loads as a burst of data writes
        REG_LUT_DATA: begin
          m         = merge_strb({16'h0, lut_q[lut_idx_q]},
                                 s_axi_wdata_in, s_axi_wstrb_in);
          lut_we    = 1'b1;
          lut_wdata = m[WORD_W-1:0];
          lut_idx_d = lut_idx_q + 12'h001;
        end
        REG_STATUS, REG_RESULT0, REG_RESULT1: begin
          bresp_d = RESP_OKAY;
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl_q    <= CTRL_RESET;
      trim_q    <= TRIM_RESET;
      lut_idx_q <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
    end else if (clk_en_in) begin
      ctrl_q    <= ctrl_d;
      trim_q    <= trim_d;
      lut_idx_q <= lut_idx_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
    end
  end

  // Table storage is data only and has no reset
  always_ff @(posedge clk_sys_in) begin
    if (clk_en_in && lut_we) begin
      lut_q[lut_idx_q] <= lut_wdata;
    end
  end

  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out  = bresp_q;

  // ==========================================================
  // Read side
  always_comb begin
    rvalid_d = rvalid_q & ~s_axi_rready_in;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (rd_hs) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      rdata_d  = '0;
      case (s_axi_araddr_in)
        REG_CTRL:     rdata_d = {30'h0, ctrl_q};
        REG_TRIM:     rdata_d = {16'h0, trim_q};
        REG_STATUS:   rdata_d = {29'h0, primed1, primed0, conv_ready};
        REG_RESULT0:  rdata_d = {18'h0, avg0};
        REG_RESULT1:  rdata_d = {16'h0, result_out};
        REG_LUT_IDX:  rdata_d = {20'h0, lut_idx_q};
        REG_LUT_DATA: rdata_d = {16'h0, lut_q[lut_idx_q]};
        default:      rresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= '0;
    end else if (clk_en_in) begin
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rresp_out  = rresp_q;
  assign s_axi_rdata_out  = rdata_q;

  // ==========================================================
  // Converter power sequencing and conversion timer
  tsc_pwr_t                power_up_state_q, power_up_state_d;
  logic [PWRUP_CNT_W-1:0]  power_up_delay_counter_q;
  logic [PWRUP_CNT_W-1:0]  power_up_delay_counter_d;
  logic [SAMPLE_CNT_W-1:0] smp_cnt_q, smp_cnt_d;
  logic                    start_q, start_d;

  always_comb begin
    power_up_state_d         = power_up_state_q;
    power_up_delay_counter_d = power_up_delay_counter_q;
    smp_cnt_d                = '0;
    start_d                  = 1'b0;
    case (power_up_state_q)
      TSC_PWR_OFF: begin
        power_up_delay_counter_d = '0;
        if (conv_en) begin
          power_up_state_d = TSC_PWR_WAIT;
        end
      end
      TSC_PWR_WAIT: begin
        power_up_delay_counter_d = power_up_delay_counter_q + 1'b1;
        if (!conv_en) begin
          power_up_state_d = TSC_PWR_OFF;
        end else if (power_up_delay_counter_q ==
                     PWRUP_CNT_W'(PWRUP_CYCLES - 1)) begin
          power_up_state_d = TSC_PWR_ON;
        end
      end
      TSC_PWR_ON: begin
        if (!conv_en) begin
          power_up_state_d = TSC_PWR_OFF;
        end else if (smp_cnt_q == SAMPLE_CNT_W'(SAMPLE_CYCLES - 1)) begin
          start_d = 1'b1;
        end else begin
          smp_cnt_d = smp_cnt_q + 1'b1;
        end
      end
      default: begin
        power_up_state_d = TSC_PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      power_up_state_q         <= TSC_PWR_OFF;
      power_up_delay_counter_q <= '0;
      smp_cnt_q                <= '0;
      start_q                  <= 1'b0;
    end else if (clk_en_in) begin
      power_up_state_q         <= power_up_state_d;
      power_up_delay_counter_q <= power_up_delay_counter_d;
      smp_cnt_q                <= smp_cnt_d;
      start_q                  <= start_d;
    end
  end

  assign conv_ready       = (power_up_state_q == TSC_PWR_ON);
  assign adc_power_en_out = (power_up_state_q != TSC_PWR_OFF);
  assign adc_start_out    = start_q & clk_en_in;
  assign adc_chan_sel_out     = SENSOR_CHANNEL;
  assign adc_single_ended_out = SENSOR_SE;

  // ==========================================================
  // First averaging stage
  logic smp_take;
  assign smp_take = adc_valid_in & conv_ready;

  tsc_avg #(
    .W (SAMPLE_W)
  ) first_averaging_buffer (
    .clk_sys_in     (clk_sys_in),
    .srst_in        (srst_in),
    .clk_en_in      (clk_en_in),
    .din_in         (adc_data_in),
    .din_valid_in   (smp_take),
    .dout_out       (avg0),
    .dout_valid_out (avg0_vld),
    .primed_out     (primed0)
  );

  // ==========================================================
  // Lookup and linear compensation
  logic [WORD_W-1:0] avg0_word;
  logic [LUT_AW-1:0] lut_addr;
  logic [WORD_W-1:0] look_q, look_d;
  logic              look_vld_q, look_vld_d;
  logic [WORD_W-1:0] comp_q, comp_d;
  logic              comp_vld_q, comp_vld_d;
  logic [WORD_W:0]   kx;

  assign avg0_word = {2'h0, avg0};
  assign lut_addr  = avg0_word[LUT_AW+TRUNC_LSB-1:TRUNC_LSB];

  always_comb begin
    look_d     = look_q;
    look_vld_d = 1'b0;
    comp_d     = comp_q;
    comp_vld_d = 1'b0;
    kx         = {1'b0, look_q[WORD_W-1:0] & {WORD_W{COMP_GAIN[0]}}};
    if (avg0_vld) begin
      look_d     = lut_q[lut_addr];
      look_vld_d = 1'b1;
    end
    if (look_vld_q) begin
      comp_vld_d = 1'b1;
      if (subtract) begin
        comp_d = (kx[WORD_W-1:0] > trim_q) ? kx[WORD_W-1:0] - trim_q
                                            : '0;
      end else begin
        kx     = kx + {1'b0, trim_q};
        comp_d = kx[WORD_W] ? '1 : kx[WORD_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      look_q     <= '0;
      look_vld_q <= 1'b0;
      comp_q     <= '0;
      comp_vld_q <= 1'b0;
    end else if (clk_en_in) begin
      look_q     <= look_d;
      look_vld_q <= look_vld_d;
      comp_q     <= comp_d;
      comp_vld_q <= comp_vld_d;
    end
  end

  // ==========================================================
  // Final averaging stage; result is (T + 40) * 10
  // trimmed value averaged
  tsc_avg #(
    .W (WORD_W)
  ) final_averaging_buffer (
    .clk_sys_in     (clk_sys_in),
    .srst_in        (srst_in),
    .clk_en_in      (clk_en_in),
    .din_in         (comp_q),
    .din_valid_in   (comp_vld_q),
    .dout_out       (result_out),
    .dout_valid_out (result_valid_out),
    .primed_out     (primed1)
  );

endmodule : tsc_top

// ==== testbench/tsc_top_properties.sv ====
// Checker for the readout path top; sees its ports only.
// Assumes clk_en_in stays high while results are timed.
module tsc_chk
  import tsc_pkg::*;
(
  input wire logic              clk_sys_in,
  input wire logic              srst_in,
  input wire logic              clk_en_in,
  input wire logic              s_axi_awvalid_in,
  input wire logic              s_axi_awready_out,
  input wire logic              s_axi_bvalid_out,
  input wire logic [1:0]        s_axi_bresp_out,
  input wire logic              s_axi_arvalid_in,
  input wire logic              s_axi_arready_out,
  input wire logic              s_axi_rvalid_out,
  input wire logic              adc_valid_in,
  input wire logic              adc_power_en_out,
  input wire logic              adc_start_out,
  input wire logic [1:0]        adc_chan_sel_out,
  input wire logic              adc_single_ended_out,
  input wire logic [WORD_W-1:0] result_out,
  input wire logic              result_valid_out
);
  // ==========================================================
  // Start pulse spacing counter
  logic [8:0] gap_q, gap_d;
  logic       seen_q, seen_d;

  always_comb begin
    gap_d  = gap_q;
    seen_d = seen_q;
    if (!adc_power_en_out) begin
      gap_d  = 9'h000;
      seen_d = 1'b0;
    end else if (adc_start_out) begin
      gap_d  = 9'h000;
      seen_d = 1'b1;
    end else if (clk_en_in) begin
      gap_d = gap_q + 9'h001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      gap_q  <= 9'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  a_chan_fixed: assert property (
    adc_chan_sel_out == 2'h0 && adc_single_ended_out)
    else $error("sensor routing changed");
  a_start_gap: assert property (
    adc_start_out && seen_q |-> gap_q == 9'(SAMPLE_CYCLES - 1))
    else $error("start pulse spacing wrong");
  a_warmup_quiet: assert property (
    $rose(adc_power_en_out) |-> !adc_start_out [*8])
    else $error("start during warm-up");
  a_off_no_result: assert property (
    !adc_power_en_out [*5] |-> !result_valid_out)
    else $error("result while converter off");
  a_result_cause: assert property (
    result_valid_out |-> $past(adc_valid_in, 4)
                         && $past(adc_power_en_out, 4))
    else $error("result without sample four cycles back");
  a_result_hold: assert property (
    !result_valid_out |-> result_out == $past(result_out))
    else $error("result changed without strobe");
  a_read_answer: assert property (
    s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_write_answer: assert property (
    s_axi_awvalid_in && s_axi_awready_out |=> s_axi_bvalid_out)
    else $error("write answer late");

  c_result: cover property (result_valid_out);
  c_start: cover property (adc_start_out && seen_q);
  c_slverr: cover property (
    s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule : tsc_chk

bind tsc_top tsc_chk u_chk (
  .clk_sys_in, .srst_in, .clk_en_in, .s_axi_awvalid_in,
  .s_axi_awready_out, .s_axi_bvalid_out, .s_axi_bresp_out,
  .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out,
  .adc_valid_in, .adc_power_en_out, .adc_start_out,
  .adc_chan_sel_out, .adc_single_ended_out, .result_out,
  .result_valid_out
);

// ==== testbench/tsc_host_model.sv ====
// Host that reads the final average and turns it into degrees.
// Assumes it sees the result strobe on the system clock.
module tsc_host_model
  import tsc_pkg::*;
(
  input  wire logic              clk_sys_in,
  input  wire logic [WORD_W-1:0] result_in,
  input  wire logic              result_valid_in,
  output int                     deg_c_out
);
  always_ff @(posedge clk_sys_in) begin
    if (result_valid_in) begin
      deg_c_out <= int'(result_in) / 10 - 40;
    end
  end
endmodule : tsc_host_model

// ==== testbench/tsc_top_tb.sv ====
// Self-checking bench of the readout path top.
// Assumes the checker file is compiled alongside and binds itself.
module tsc_top_tb
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals and instances
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        clk_en = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [13:0] adc_data = 14'h0;
  logic        adc_valid = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        power, start, se, res_v;
  logic [1:0]  bresp, rresp, chan;
  logic [31:0] rdata;
  logic [15:0] res;
  int          deg;
  int          failures = 0;
  int          checks = 0;
  int          trim_v = 0;
  bit          sub_v = 1'b0;
  int          exp_res = 0;
  int          w0 [8] = '{default: 0};
  int          w1 [8] = '{default: 0};

  always #25 clk = ~clk;

  tsc_top dut (
    .clk_sys_in(clk), .srst_in(srst), .clk_en_in(clk_en),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .adc_data_in(adc_data),
    .adc_valid_in(adc_valid), .adc_power_en_out(power),
    .adc_start_out(start), .adc_chan_sel_out(chan),
    .adc_single_ended_out(se), .result_out(res),
    .result_valid_out(res_v)
  );

  tsc_host_model host (
    .clk_sys_in(clk), .result_in(res), .result_valid_in(res_v),
    .deg_c_out(deg)
  );

  // ==========================================================
  // Shared tasks
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, exp, input string w);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask : chk

  // Bounded wait, sampled mid-cycle where outputs are settled
  task automatic wait_hi(ref logic s, input string w);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (s !== 1'b1 && n < 1000);
    if (s !== 1'b1) begin
      failures++;
      $display("BAD %0t timeout on %s", $time, w);
      give_verdict();
    end
  endtask : wait_hi

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    wait_hi(awready, "write address");
    chk(32'(wready), 32'h1, "write data ready");
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    bready  <= 1'b1;
    wait_hi(bvalid, "write response");
    chk(32'(bresp), 32'(er), "write response code");
    @(posedge clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    wait_hi(arready, "read address");
    @(posedge clk);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    wait_hi(rvalid, "read data");
    chk(rdata, ed, "read data");
    chk(32'(rresp), 32'(er), "read response code");
    @(posedge clk);
    rready <= 1'b0;
  endtask : rd

  // One converter sample, with the expected pipeline outcome
  task automatic feed(input logic [13:0] s);
    int a0;
    int wd;
    for (int i = 7; i > 0; i--) begin
      w0[i] = w0[i-1];
      w1[i] = w1[i-1];
    end
    w0[0] = int'(s);
    a0 = w0.sum() >> 3;
    wd = (a0 >> 2) + 600;
    if (sub_v) w1[0] = (wd > trim_v) ? wd - trim_v : 0;
    else w1[0] = (wd + trim_v > 65535) ? 65535 : wd + trim_v;
    exp_res = w1.sum() >> 3;
    wr(REG_LUT_IDX, 32'(a0 >> 2), RESP_OKAY);
    wr(REG_LUT_DATA, 32'(wd), RESP_OKAY);
    wait_hi(start, "start pulse");
    @(posedge clk);
    adc_data  <= s;
    adc_valid <= 1'b1;
    @(posedge clk);
    adc_valid <= 1'b0;
    wait_hi(res_v, "result strobe");
    chk(32'(res), 32'(exp_res), "final average");
    // Bus requests start right after a rising edge
    @(posedge clk);
    rd(REG_RESULT0, 32'(a0), RESP_OKAY);
  endtask : feed

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(REG_CTRL, 32'h1, RESP_OKAY);
    rd(REG_TRIM, 32'h0, RESP_OKAY);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h5, RESP_SLVERR);
    chk(32'({chan, se}), 32'h1, "sensor routing");
  endtask : t_regs

  task automatic t_power();
    wait_hi(start, "first start");
    @(posedge clk);
    rd(REG_STATUS, 32'h1, RESP_OKAY);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    @(negedge clk);
    chk(32'(power), 32'h0, "power off");
    @(posedge clk);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    @(negedge clk);
    chk(32'(power), 32'h1, "power on");
    @(posedge clk);
    rd(REG_STATUS, 32'h0, RESP_OKAY);
  endtask : t_power

  task automatic t_pipe();
    for (int i = 0; i < 9; i++) begin
      feed(14'h3fff - 14'(i * 291));
    end
    rd(REG_STATUS, 32'h7, RESP_OKAY);
  endtask : t_pipe

  // Low clock enable holds the bus and the sequencer still
  task automatic t_freeze();
    clk_en  <= 1'b0;
    araddr  <= REG_STATUS;
    arvalid <= 1'b1;
    repeat (4) @(negedge clk);
    chk(32'({arready, rvalid, start}), 32'h0, "frozen");
    @(posedge clk);
    clk_en <= 1'b1;
    wait_hi(arready, "read after freeze");
    @(posedge clk);
    arvalid <= 1'b0;
    rready  <= 1'b1;
    wait_hi(rvalid, "read data after freeze");
    chk(rdata, 32'h7, "status after freeze");
    @(posedge clk);
    rready <= 1'b0;
  endtask : t_freeze

  // Trim in both directions, then both saturation limits
  task automatic t_trim();
    trim_v = 7;
    wr(REG_TRIM, 32'h7, RESP_OKAY);
    feed(14'h1c58);
    sub_v = 1'b1;
    wr(REG_CTRL, 32'h3, RESP_OKAY);
    feed(14'h1c58);
    trim_v = 65535;
    wr(REG_TRIM, 32'hffff, RESP_OKAY);
    feed(14'h0100);
    sub_v = 1'b0;
    wr(REG_CTRL, 32'h1, RESP_OKAY);
    feed(14'h2000);
    chk(32'(deg), 32'(exp_res / 10 - 40), "degrees");
    rd(REG_RESULT1, 32'(exp_res), RESP_OKAY);
  endtask : t_trim

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_power();
    t_pipe();
    t_freeze();
    t_trim();
    give_verdict();
  end
endmodule : tsc_top_tb
